// File: hdl/rtc_consts.vh
// Register map, field positions and reset values of the real-time counter
`ifndef RTC_CONSTS_VH
`define RTC_CONSTS_VH

// Register indexes on the plain register port
`define RTC_ADDR_W 5
`define RTC_REG_CTRL 5'h00
`define RTC_REG_STATUS 5'h01
`define RTC_REG_INT_MASK 5'h02
`define RTC_REG_INT_FLAGS 5'h03
`define RTC_REG_EVENT_EN 5'h04
`define RTC_REG_DEBUG 5'h05
`define RTC_REG_CLK_SELECT 5'h07
`define RTC_REG_COUNT 5'h08
`define RTC_REG_PERIOD 5'h0A
`define RTC_REG_COMPARE 5'h0C
`define RTC_REG_TICK_CTRL 5'h10

// Control register fields
`define RTC_CTRL_ENABLE 0
`define RTC_CTRL_PRESC_LSB 1
`define RTC_CTRL_PRESC_MSB 4
`define RTC_CTRL_STANDBY 7

// Flag, mask and event enable layout
`define RTC_FLAG_WRAP 0
`define RTC_FLAG_MATCH 1
`define RTC_FLAG_TICK 2

// Periodic tick control fields
`define RTC_TICK_ENABLE 0
`define RTC_TICK_SEL_LSB 1
`define RTC_TICK_SEL_MSB 4

// Clock source encodings
`define RTC_SRC_CRYSTAL 2'h0
`define RTC_SRC_EXTERNAL 2'h1
`define RTC_SRC_LP_OSC 2'h2
`define RTC_SRC_LP_OSC_DIV 2'h3

// Reset values
`define RTC_RESET_PERIOD 16'hFFFF
`define RTC_RESET_ZERO 16'h0000

// Internal oscillator divider: 32 source edges per tick
`define RTC_OSC_DIV_LAST 5'h1F

`endif

// File: hdl/rtc_sync_edge.v
// Two-flop synchroniser with rising-edge detector for a slow clock pin
`timescale 1ns/1ps
module rtc_sync_edge (
    input wire clk_i,    // System clock
    input wire reset_i,  // Synchronous reset, active high
    input wire async_i,  // Asynchronous slow clock level
    output reg rise_o    // One-cycle pulse on a rising edge
);
    reg meta;
    reg stable;
    reg stable_d;

    // First flop feeds only the second; edge logic reads later stages
    always @(posedge clk_i) begin
        if (reset_i) begin
            meta <= 1'b0;
            stable <= 1'b0;
            stable_d <= 1'b0;
            rise_o <= 1'b0;
        end else begin
            meta <= async_i;
            stable <= meta;
            stable_d <= stable;
            rise_o <= stable & ~stable_d;
        end
    end
endmodule // rtc_sync_edge

// File: hdl/rtc_counter_top.v
// Real-time counter with prescaler, compare, wrap and periodic tick timer
`timescale 1ns/1ps
`include "rtc_consts.vh"

module rtc_counter_top (
    input wire SYS_CLK_I,            // System clock, 50 MHz
    input wire RESET_I,              // Synchronous reset, active high
    input wire [4:0] ADDR_I,         // Register index
    input wire [15:0] WDATA_I,       // Write data
    input wire WRITE_I,              // Write strobe
    input wire READ_I,               // Read strobe
    output reg [15:0] RDATA_O,       // Read data, cycle after strobe
    input wire CRYSTAL_CLK_I,        // External crystal oscillator
    input wire EXT_CLK_I,            // External clock signal
    input wire LP_OSC_CLK_I,         // Internal low power oscillator
    input wire DEBUG_HALT_I,         // Processor halted for debug
    input wire STANDBY_I,            // Standby sleep mode active
    output reg IRQ_O,                // Level interrupt request
    output reg WRAP_EVENT_O,         // Count wrap event pulse
    output reg MATCH_EVENT_O,        // Compare match event pulse
    output reg TICK_EVENT_O          // Periodic tick event pulse
);
    // Reference edges are caught by sampling, so a reference faster than
    // a quarter of the system clock would lose edges

    // Synchronised rising edges of each source pin
    wire crystal_rise;
    wire ext_rise;
    wire osc_rise;

    // Software visible registers
    reg run_enable;
    reg [3:0] presc_sel;
    reg run_in_standby;
    reg [2:0] int_mask;
    reg [2:0] int_flags;
    reg [2:0] event_en;
    reg debug_keep_running;
    reg [1:0] clk_select;
    reg [15:0] count;
    reg [15:0] period;
    reg [15:0] compare_match;
    reg tick_enable;
    reg [3:0] tick_sel;

    // Internal state
    reg [4:0] osc_div;
    reg osc_div_rise;
    reg [14:0] presc_cnt;
    reg [15:0] tick_cnt;
    reg ref_tick;
    reg [2:0] next_flags;
    reg [15:0] next_rdata;

    wire halted;
    wire counter_run;
    wire tick_run;
    wire [14:0] presc_last;
    wire presc_tick;
    wire [15:0] tick_mask;
    wire tick_fire;
    wire count_step;
    wire wrap_hit;
    wire match_hit;
    wire [2:0] clear_req;

    // One synchroniser per source pin
    rtc_sync_edge u_sync_crystal (
        .clk_i(SYS_CLK_I),
        .reset_i(RESET_I),
        .async_i(CRYSTAL_CLK_I),
        .rise_o(crystal_rise)
    );

    rtc_sync_edge u_sync_ext (
        .clk_i(SYS_CLK_I),
        .reset_i(RESET_I),
        .async_i(EXT_CLK_I),
        .rise_o(ext_rise)
    );

    rtc_sync_edge u_sync_osc (
        .clk_i(SYS_CLK_I),
        .reset_i(RESET_I),
        .async_i(LP_OSC_CLK_I),
        .rise_o(osc_rise)
    );

    // Internal oscillator divided by 32 for the slowest source
    always @(posedge SYS_CLK_I) begin
        if (RESET_I) begin
            osc_div <= 5'h00;
            osc_div_rise <= 1'b0;
        end else begin
            osc_div_rise <= osc_rise && (osc_div == `RTC_OSC_DIV_LAST);
            if (osc_rise) begin
                osc_div <= osc_div + 5'h01;
            end
        end
    end

    // Source select; one reference tick feeds both timers
    always @(posedge SYS_CLK_I) begin
        if (RESET_I) begin
            ref_tick <= 1'b0;
        end else begin
            case (clk_select)
                `RTC_SRC_CRYSTAL: ref_tick <= crystal_rise;
                `RTC_SRC_EXTERNAL: ref_tick <= ext_rise;
                `RTC_SRC_LP_OSC: ref_tick <= osc_rise;
                default: ref_tick <= osc_div_rise;
            endcase
        end
    end

    // Debug halt freezes both timers unless told to keep running
    assign halted = DEBUG_HALT_I & ~debug_keep_running;
    // Standby stops the counter only; the tick timer ignores sleep
    assign counter_run = run_enable & ~halted &
        ~(STANDBY_I & ~run_in_standby);
    assign tick_run = tick_enable & ~halted;

    // Power-of-two prescaler, divide by 1 up to 32768
    assign presc_last = (15'h0001 << presc_sel) - 15'h0001;
    assign presc_tick = ref_tick & (presc_cnt == presc_last);

    always @(posedge SYS_CLK_I) begin
        if (RESET_I) begin
            presc_cnt <= 15'h0000;
        end else if (!counter_run) begin
            presc_cnt <= 15'h0000;
        end else if (presc_tick) begin
            presc_cnt <= 15'h0000;
        end else if (ref_tick) begin
            presc_cnt <= presc_cnt + 15'h0001;
        end
    end

    // Compare and wrap are judged on the count that steps away
    assign count_step = counter_run & presc_tick;
    assign wrap_hit = count_step & (count == period);
    assign match_hit = count_step & (count == compare_match);

    // Periodic tick: n = 2^(sel+1), select 0 means stopped; the top
    // select is held at 32768 so no setting goes past the longest period
    assign tick_mask = (tick_sel == 4'hF) ? 16'h7FFF :
        ((16'h0002 << tick_sel) - 16'h0001);
    assign tick_fire = tick_run & ref_tick & (tick_sel != 4'h0) &
        ((tick_cnt & tick_mask) == tick_mask);

    always @(posedge SYS_CLK_I) begin
        if (RESET_I) begin
            tick_cnt <= 16'h0000;
        end else if (!tick_run) begin
            tick_cnt <= 16'h0000;
        end else if (ref_tick) begin
            tick_cnt <= tick_cnt + 16'h0001;
        end
    end

    // Write-one clears, but a fresh event in the same cycle wins
    assign clear_req = (WRITE_I && ADDR_I == `RTC_REG_INT_FLAGS) ?
        WDATA_I[2:0] : 3'h0;

    always @* begin
        next_flags = int_flags & ~clear_req;
        if (wrap_hit) begin
            next_flags[`RTC_FLAG_WRAP] = 1'b1;
        end
        if (match_hit) begin
            next_flags[`RTC_FLAG_MATCH] = 1'b1;
        end
        if (tick_fire) begin
            next_flags[`RTC_FLAG_TICK] = 1'b1;
        end
    end

    // Flags, interrupt and event outputs
    always @(posedge SYS_CLK_I) begin
        if (RESET_I) begin
            int_flags <= 3'h0;
            IRQ_O <= 1'b0;
            WRAP_EVENT_O <= 1'b0;
            MATCH_EVENT_O <= 1'b0;
            TICK_EVENT_O <= 1'b0;
        end else begin
            int_flags <= next_flags;
            IRQ_O <= |(next_flags & int_mask);
            WRAP_EVENT_O <= wrap_hit & event_en[`RTC_FLAG_WRAP];
            MATCH_EVENT_O <= match_hit & event_en[`RTC_FLAG_MATCH];
            TICK_EVENT_O <= tick_fire & event_en[`RTC_FLAG_TICK];
        end
    end

    // Counter: software write wins over a step in the same cycle
    always @(posedge SYS_CLK_I) begin
        if (RESET_I) begin
            count <= `RTC_RESET_ZERO;
        end else if (WRITE_I && ADDR_I == `RTC_REG_COUNT) begin
            count <= WDATA_I;
        end else if (wrap_hit) begin
            count <= `RTC_RESET_ZERO;
        end else if (count_step) begin
            count <= count + 16'h0001;
        end
    end

    // Configuration registers; values apply on the next cycle
    always @(posedge SYS_CLK_I) begin
        if (RESET_I) begin
            run_enable <= 1'b0;
            presc_sel <= 4'h0;
            run_in_standby <= 1'b0;
            int_mask <= 3'h0;
            event_en <= 3'h0;
            debug_keep_running <= 1'b0;
            clk_select <= `RTC_SRC_CRYSTAL;
            period <= `RTC_RESET_PERIOD;
            compare_match <= `RTC_RESET_ZERO;
            tick_enable <= 1'b0;
            tick_sel <= 4'h0;
        end else if (WRITE_I) begin
            case (ADDR_I)
                `RTC_REG_CTRL: begin
                    run_enable <= WDATA_I[`RTC_CTRL_ENABLE];
                    presc_sel <=
                        WDATA_I[`RTC_CTRL_PRESC_MSB:`RTC_CTRL_PRESC_LSB];
                    run_in_standby <= WDATA_I[`RTC_CTRL_STANDBY];
                end
                `RTC_REG_INT_MASK: begin
                    int_mask <= WDATA_I[2:0];
                end
                `RTC_REG_EVENT_EN: begin
                    event_en <= WDATA_I[2:0];
                end
                `RTC_REG_DEBUG: begin
                    debug_keep_running <= WDATA_I[0];
                end
                `RTC_REG_CLK_SELECT: begin
                    clk_select <= WDATA_I[1:0];
                end
                `RTC_REG_PERIOD: begin
                    period <= WDATA_I;
                end
                `RTC_REG_COMPARE: begin
                    compare_match <= WDATA_I;
                end
                `RTC_REG_TICK_CTRL: begin
                    tick_enable <= WDATA_I[`RTC_TICK_ENABLE];
                    tick_sel <= WDATA_I[`RTC_TICK_SEL_MSB:`RTC_TICK_SEL_LSB];
                end
                default: begin
                    run_enable <= run_enable;
                end
            endcase
        end
    end

    // Read mux; status shows running state, unmapped reads give zero
    always @* begin
        next_rdata = 16'h0000;
        case (ADDR_I)
            `RTC_REG_CTRL: begin
                next_rdata[`RTC_CTRL_ENABLE] = run_enable;
                next_rdata[`RTC_CTRL_PRESC_MSB:`RTC_CTRL_PRESC_LSB] =
                    presc_sel;
                next_rdata[`RTC_CTRL_STANDBY] = run_in_standby;
            end
            `RTC_REG_STATUS: begin
                next_rdata[0] = counter_run;
                next_rdata[1] = tick_run;
            end
            `RTC_REG_INT_MASK: next_rdata[2:0] = int_mask;
            `RTC_REG_INT_FLAGS: next_rdata[2:0] = int_flags;
            `RTC_REG_EVENT_EN: next_rdata[2:0] = event_en;
            `RTC_REG_DEBUG: next_rdata[0] = debug_keep_running;
            `RTC_REG_CLK_SELECT: next_rdata[1:0] = clk_select;
            `RTC_REG_COUNT: next_rdata = count;
            `RTC_REG_PERIOD: next_rdata = period;
            `RTC_REG_COMPARE: next_rdata = compare_match;
            `RTC_REG_TICK_CTRL: begin
                next_rdata[`RTC_TICK_ENABLE] = tick_enable;
                next_rdata[`RTC_TICK_SEL_MSB:`RTC_TICK_SEL_LSB] = tick_sel;
            end
            default: next_rdata = 16'h0000;
        endcase
    end

    // Read data stands only in the cycle after the strobe
    always @(posedge SYS_CLK_I) begin
        if (RESET_I) begin
            RDATA_O <= 16'h0000;
        end else if (READ_I) begin
            RDATA_O <= next_rdata;
        end else begin
            RDATA_O <= 16'h0000;
        end
    end
endmodule // rtc_counter_top

// File: dv/rtc_counter_props.sv
// Port-level assertion checker for the real-time counter
`timescale 1ns/1ps
`include "rtc_consts.vh"
module rtc_counter_props (
    input wire SYS_CLK_I,       // System clock
    input wire RESET_I,         // Synchronous reset
    input wire [4:0] ADDR_I,    // Register index
    input wire [15:0] WDATA_I,  // Write data
    input wire WRITE_I,         // Write strobe
    input wire READ_I,          // Read strobe
    input wire [15:0] RDATA_O,  // Read data
    input wire DEBUG_HALT_I,    // Debug halt
    input wire STANDBY_I,       // Standby sleep
    input wire IRQ_O,           // Interrupt request
    input wire WRAP_EVENT_O,    // Wrap pulse
    input wire MATCH_EVENT_O,   // Match pulse
    input wire TICK_EVENT_O     // Tick pulse
);
    reg [2:0] mask_sh;
    reg [2:0] ev_sh;
    reg dbg_sh;
    reg stby_sh;
    wire [2:0] ev = {TICK_EVENT_O, MATCH_EVENT_O, WRAP_EVENT_O};
    wire wr_flags = WRITE_I && ADDR_I == `RTC_REG_INT_FLAGS;

    // Shadow the gating fields; only writes can change them
    always @(posedge SYS_CLK_I) begin
        if (RESET_I) begin
            mask_sh <= 3'h0;
            ev_sh <= 3'h0;
            dbg_sh <= 1'b0;
            stby_sh <= 1'b0;
        end else if (WRITE_I) begin
            if (ADDR_I == `RTC_REG_INT_MASK)
                mask_sh <= WDATA_I[2:0];
            if (ADDR_I == `RTC_REG_EVENT_EN)
                ev_sh <= WDATA_I[2:0];
            if (ADDR_I == `RTC_REG_DEBUG)
                dbg_sh <= WDATA_I[0];
            if (ADDR_I == `RTC_REG_CTRL)
                stby_sh <= WDATA_I[`RTC_CTRL_STANDBY];
        end
    end

    default clocking cb @(posedge SYS_CLK_I); endclocking
    default disable iff (RESET_I);

    read_idle_zero_a: assert property (
        !$past(READ_I) |-> RDATA_O == 16'h0000)
        else $error("read data not zero outside read cycle");
    reset_quiet_a: assert property (
        $fell(RESET_I) |-> ev == 3'h0 && !IRQ_O)
        else $error("output active right after reset");
    tick_spacing_a: assert property (
        TICK_EVENT_O |=> !TICK_EVENT_O [*8])
        else $error("tick pulses too close together");
    irq_follows_a: assert property (
        (ev & mask_sh & $past(mask_sh)) != 3'h0 |-> IRQ_O)
        else $error("unmasked event without interrupt");
    irq_masked_a: assert property (
        mask_sh == 3'h0 && $past(mask_sh) == 3'h0 |-> !IRQ_O)
        else $error("interrupt while all sources masked");
    irq_clear_a: assert property (
        wr_flags && WDATA_I[2:0] == 3'h7 && ev_sh == 3'h7
        ##1 (ev == 3'h0) [*2] |-> !IRQ_O)
        else $error("interrupt stays after flags cleared");
    halt_freeze_a: assert property (
        (DEBUG_HALT_I && !dbg_sh) [*3] |-> ev == 3'h0)
        else $error("event while halted for debug");
    standby_freeze_a: assert property (
        (STANDBY_I && !stby_sh) [*3] |-> !WRAP_EVENT_O && !MATCH_EVENT_O)
        else $error("counter event in standby without run bit");

    wrap_irq_c: cover property (WRAP_EVENT_O && IRQ_O);
    tick_c: cover property (TICK_EVENT_O);
    halt_c: cover property (DEBUG_HALT_I && dbg_sh && WRAP_EVENT_O);
endmodule // rtc_counter_props

bind rtc_counter_top rtc_counter_props i_rtc_counter_props (
    .SYS_CLK_I(SYS_CLK_I), .RESET_I(RESET_I), .ADDR_I(ADDR_I),
    .WDATA_I(WDATA_I), .WRITE_I(WRITE_I), .READ_I(READ_I),
    .RDATA_O(RDATA_O), .DEBUG_HALT_I(DEBUG_HALT_I), .STANDBY_I(STANDBY_I),
    .IRQ_O(IRQ_O), .WRAP_EVENT_O(WRAP_EVENT_O),
    .MATCH_EVENT_O(MATCH_EVENT_O), .TICK_EVENT_O(TICK_EVENT_O));

// File: dv/rtc_counter_with_periodic_timer_bench.sv
// Self-checking bench for the real-time counter
`timescale 1ns/1ps
`include "rtc_consts.vh"
module rtc_counter_with_periodic_timer_bench;
    reg clk = 1'b0;
    reg rst = 1'b1;
    reg [4:0] addr = 5'h00;
    reg [15:0] wdata = 16'h0000;
    reg wr = 1'b0;
    reg rd = 1'b0;
    reg xtal = 1'b0;
    reg extc = 1'b0;
    reg osc = 1'b0;
    reg halt = 1'b0;
    reg stby = 1'b0;
    wire [15:0] rdata;
    wire irq;
    wire [2:0] ev;
    int failures = 0;
    int compares = 0;
    int n;
    int src_gap[4] = '{10, 9, 7, 224};

    always #10 clk = ~clk;
    // References stay far below a quarter of the bus clock
    initial #3 forever #100 xtal = ~xtal;
    initial #7 forever #90 extc = ~extc;
    initial #13 forever #70 osc = ~osc;

    rtc_counter_top i_rtc_counter_top (
        .SYS_CLK_I(clk), .RESET_I(rst), .ADDR_I(addr), .WDATA_I(wdata),
        .WRITE_I(wr), .READ_I(rd), .RDATA_O(rdata), .CRYSTAL_CLK_I(xtal),
        .EXT_CLK_I(extc), .LP_OSC_CLK_I(osc), .DEBUG_HALT_I(halt),
        .STANDBY_I(stby), .IRQ_O(irq), .WRAP_EVENT_O(ev[0]),
        .MATCH_EVENT_O(ev[1]), .TICK_EVENT_O(ev[2]));

    task automatic chk(input string what, input [15:0] exp, input [15:0] got);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Single clock: a write lands at its strobe edge, no busy poll
    task automatic wreg(input [4:0] a, input [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // Read data is only valid in the cycle after the strobe
    task automatic rreg(input [4:0] a, input [15:0] exp, input string what);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(what, exp, rdata);
    endtask
    // Cycles to the next pulse on one event line, capped at lim
    task automatic waitp(input int i, input int lim);
        n = 0;
        @(posedge clk);
        #1;
        while (ev[i] !== 1'b1 && n < lim) begin
            @(posedge clk);
            #1;
            n++;
        end
    endtask
    task automatic gap(input int i, input [15:0] exp, input string what);
        waitp(i, 2000);
        waitp(i, 2000);
        chk(what, exp, 16'(n + 1));
    endtask
    task automatic conclude;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // Watchdog well beyond the few thousand cycles the tests need
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        conclude();
    end

    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rreg(`RTC_REG_PERIOD, 16'hFFFF, "period");
        rreg(`RTC_REG_COUNT, 16'h0000, "count");
        rreg(5'h1F, 16'h0000, "unmapped");
        $display("test reset done");
        // Configure before enabling; count runs 0,1,2 then wraps
        wreg(`RTC_REG_PERIOD, 16'h0002);
        wreg(`RTC_REG_COMPARE, 16'h0001);
        wreg(`RTC_REG_EVENT_EN, 16'h0007);
        wreg(`RTC_REG_INT_MASK, 16'h0001);
        rreg(`RTC_REG_COMPARE, 16'h0001, "compare");
        rreg(`RTC_REG_EVENT_EN, 16'h0007, "event enable");
        wreg(`RTC_REG_CTRL, 16'h0001);
        gap(0, 16'h001E, "wrap gap");
        rreg(`RTC_REG_COUNT, 16'h0000, "count after wrap");
        waitp(1, 2000);
        waitp(0, 2000);
        chk("match to wrap", 16'h000A, 16'(n + 1));
        rreg(`RTC_REG_INT_FLAGS, 16'h0003, "flags");
        wreg(`RTC_REG_CTRL, 16'h0003);
        gap(0, 16'h003C, "prescale 2");
        wreg(`RTC_REG_CTRL, 16'h0007);
        gap(0, 16'h00F0, "prescale 8");
        rreg(`RTC_REG_CTRL, 16'h0007, "ctrl");
        rreg(`RTC_REG_STATUS, 16'h0001, "status run");
        $display("test count done");
        chk("irq", 16'h0001, {15'h0000, irq});
        wreg(`RTC_REG_CTRL, 16'h0000);
        waitp(0, 100);
        chk("stopped", 16'h0064, 16'(n));
        rreg(`RTC_REG_STATUS, 16'h0000, "status stop");
        wreg(`RTC_REG_COUNT, 16'h1234);
        rreg(`RTC_REG_COUNT, 16'h1234, "count write");
        wreg(`RTC_REG_INT_FLAGS, 16'h0002);
        rreg(`RTC_REG_INT_FLAGS, 16'h0001, "flags w1c");
        wreg(`RTC_REG_INT_FLAGS, 16'h0000);
        rreg(`RTC_REG_INT_FLAGS, 16'h0001, "flags w0");
        chk("irq held", 16'h0001, {15'h0000, irq});
        wreg(`RTC_REG_INT_MASK, 16'h0000);
        rreg(`RTC_REG_INT_MASK, 16'h0000, "mask");
        chk("irq masked", 16'h0000, {15'h0000, irq});
        wreg(`RTC_REG_INT_MASK, 16'h0001);
        wreg(`RTC_REG_INT_FLAGS, 16'h0007);
        rreg(`RTC_REG_INT_FLAGS, 16'h0000, "flags clear");
        chk("irq clear", 16'h0000, {15'h0000, irq});
        $display("test irq done");
        // Tick runs with the counter disabled
        for (int s = 1; s < 4; s++) begin
            wreg(`RTC_REG_TICK_CTRL, 16'((s << 1) | 1));
            gap(2, 16'(20 << s), "tick gap");
        end
        rreg(`RTC_REG_STATUS, 16'h0002, "status tick");
        rreg(`RTC_REG_TICK_CTRL, 16'h0007, "tick ctrl");
        rreg(`RTC_REG_INT_FLAGS, 16'h0004, "tick flag");
        wreg(`RTC_REG_TICK_CTRL, 16'h0003);
        wreg(`RTC_REG_CLK_SELECT, 16'(`RTC_SRC_EXTERNAL));
        gap(2, 16'h0024, "tick on ext");
        wreg(`RTC_REG_TICK_CTRL, 16'h0000);
        $display("test tick done");
        // Period zero wraps on every step: the gap is one reference period
        wreg(`RTC_REG_PERIOD, 16'h0000);
        wreg(`RTC_REG_COUNT, 16'h0000);
        wreg(`RTC_REG_CTRL, 16'h0001);
        for (int c = 0; c < 4; c++) begin
            wreg(`RTC_REG_CLK_SELECT, 16'(c));
            gap(0, 16'(src_gap[c]), "source gap");
        end
        rreg(`RTC_REG_CLK_SELECT, 16'h0003, "clock select");
        $display("test source done");
        wreg(`RTC_REG_CLK_SELECT, 16'(`RTC_SRC_CRYSTAL));
        halt <= 1'b1;
        waitp(0, 100);
        chk("halted", 16'h0064, 16'(n));
        rreg(`RTC_REG_STATUS, 16'h0000, "status halt");
        wreg(`RTC_REG_DEBUG, 16'h0001);
        rreg(`RTC_REG_DEBUG, 16'h0001, "debug");
        gap(0, 16'h000A, "halt run");
        @(posedge clk);
        halt <= 1'b0;
        wreg(`RTC_REG_DEBUG, 16'h0000);
        $display("test debug done");
        stby <= 1'b1;
        wreg(`RTC_REG_TICK_CTRL, 16'h0003);
        gap(2, 16'h0028, "tick standby");
        waitp(0, 100);
        chk("standby", 16'h0064, 16'(n));
        rreg(`RTC_REG_STATUS, 16'h0002, "status standby");
        wreg(`RTC_REG_CTRL, 16'h0081);
        gap(0, 16'h000A, "standby run");
        @(posedge clk);
        stby <= 1'b0;
        $display("test standby done");
        conclude();
    end
endmodule // rtc_counter_with_periodic_timer_bench
